// >>> verilog/dub_uart_defs.vh
`ifndef DUB_UART_DEFS_VH
`define DUB_UART_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define DUB_ADDR_POWER_CONTROL 8'h87
`define DUB_ADDR_PORT0_CONTROL 8'h98
`define DUB_ADDR_PORT0_BUFFER 8'h99
`define DUB_ADDR_PORT1_CONTROL 8'h9B
`define DUB_ADDR_PORT1_BUFFER 8'h9C
`define DUB_ADDR_BAUD_SOURCE 8'hD8
`define DUB_ADDR_PORT0_RELOAD_LO 8'hA1
`define DUB_ADDR_PORT0_RELOAD_HI 8'hA2
`define DUB_ADDR_PORT1_RELOAD_LO 8'hA3
`define DUB_ADDR_PORT1_RELOAD_HI 8'hA4
`define DUB_ADDR_FRAME_OPTIONS 8'hA5

// ****************************************
// Field positions
// ****************************************
`define DUB_PC_RATE_DOUBLE 7
`define DUB_PC_STOP 1
`define DUB_PC_IDLE 0
`define DUB_CT_MODE_HI 7
`define DUB_CT_MODE_LO 6
`define DUB_CT_MULTIPROC 5
`define DUB_CT_RX_ENABLE 4
`define DUB_CT_TX_NINTH 3
`define DUB_CT_RX_NINTH 2
`define DUB_CT_TX_DONE 1
`define DUB_CT_RX_DONE 0
`define DUB_BS_INTERNAL 7
`define DUB_FO_PARITY_EN0 0
`define DUB_FO_PARITY_ODD0 1
`define DUB_FO_TWO_STOP0 2
`define DUB_FO_PARITY_EN1 4
`define DUB_FO_PARITY_ODD1 5
`define DUB_FO_TWO_STOP1 6

// ****************************************
// Reset values
// ****************************************
`define DUB_RST_BYTE 8'h00
`define DUB_RST_RELOAD_LO 8'hFF
`define DUB_RST_RELOAD_HI 2'h3

// ****************************************
// Timing counts
// ****************************************
`define DUB_OVERSAMPLE_LAST 4'hF
`define DUB_START_MID 4'h7
`define DUB_RELOAD_TOP 10'h3FF

`endif

// >>> verilog/dub_baud.v
`timescale 1ns/1ns
`default_nettype none
`include "dub_uart_defs.vh"

// ****************************************
// Reload baud generator
// ****************************************
// Counts up from the reload value and pulses tick when it wraps past the top.
module dub_baud #(
	parameter WIDTH = 10
) (
	input wire clock,
	input wire rst,
	input wire [WIDTH-1:0] reload,
	output reg tick
);

	reg [WIDTH-1:0] count_q;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= `DUB_RELOAD_TOP;
			tick <= 1'b0;
		end else if (count_q == `DUB_RELOAD_TOP) begin
			count_q <= reload;
			tick <= 1'b1;
		end else begin
			count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> verilog/dub_serial.v
`timescale 1ns/1ns
`default_nettype none
`include "dub_uart_defs.vh"

// ****************************************
// One serial port engine
// ****************************************
// Transmitter and receiver run side by side on a 16x oversampling enable.
module dub_serial (
	input wire clock,
	input wire rst,
	input wire tick,
	input wire nine_en,
	input wire two_stop,
	input wire tx_start,
	input wire [7:0] tx_data,
	input wire tx_ninth,
	output reg tx_pin,
	output reg tx_done,
	input wire rx_enable,
	input wire rx_level,
	output reg rx_done,
	output reg [7:0] rx_data,
	output reg rx_ninth
);

	localparam RX_IDLE = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA = 2'b10;

	reg [11:0] tx_shift_q;
	reg [3:0] tx_bits_q;
	reg [3:0] tx_tick_q;
	reg tx_busy_q;
	reg [1:0] rx_state_q;
	reg [3:0] rx_tick_q;
	reg [3:0] rx_bits_q;
	reg [9:0] rx_shift_q;
	wire [9:0] rx_shift_d;

	assign rx_shift_d = {rx_level, rx_shift_q[9:1]};

	// ****************************************
	// Transmitter
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_shift_q <= 12'hFFF;
			tx_bits_q <= 4'h0;
			tx_tick_q <= 4'h0;
			tx_busy_q <= 1'b0;
			tx_pin <= 1'b1;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (!tx_busy_q) begin
				if (tx_start) begin
					// Start bit low, data LSB first, then ninth bit and stop bits high.
					tx_shift_q <= nine_en ? {2'b11, tx_ninth, tx_data, 1'b0} : {3'b111, tx_data, 1'b0};
					tx_bits_q <= 4'hA + {3'b000, nine_en} + {3'b000, two_stop};
					tx_tick_q <= 4'h0;
					tx_busy_q <= 1'b1;
				end
			end else if (tick) begin
				if (tx_tick_q == 4'h0) begin
					tx_pin <= tx_shift_q[0];
					tx_shift_q <= {1'b1, tx_shift_q[11:1]};
				end
				tx_tick_q <= tx_tick_q + 4'h1;
				if (tx_tick_q == `DUB_OVERSAMPLE_LAST) begin
					tx_bits_q <= tx_bits_q - 4'h1;
					if (tx_bits_q == 4'h1) begin
						tx_busy_q <= 1'b0;
						tx_done <= 1'b1;
					end
				end
			end
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_state_q <= RX_IDLE;
			rx_tick_q <= 4'h0;
			rx_bits_q <= 4'h0;
			rx_shift_q <= 10'h000;
			rx_done <= 1'b0;
			rx_data <= 8'h00;
			rx_ninth <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rx_enable) begin
				rx_state_q <= RX_IDLE;
			end else begin
				case (rx_state_q)
				RX_IDLE: begin
					if (!rx_level) begin
						rx_state_q <= RX_START;
						rx_tick_q <= 4'h0;
					end
				end
				RX_START: begin
					if (tick) begin
						rx_tick_q <= rx_tick_q + 4'h1;
						if (rx_tick_q == `DUB_START_MID) begin
							// A start bit that is high again at mid bit is a glitch.
							rx_state_q <= rx_level ? RX_IDLE : RX_DATA;
							rx_tick_q <= 4'h0;
							rx_bits_q <= 4'h9 + {3'b000, nine_en};
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_tick_q <= rx_tick_q + 4'h1;
						if (rx_tick_q == `DUB_OVERSAMPLE_LAST) begin
							rx_shift_q <= rx_shift_d;
							rx_bits_q <= rx_bits_q - 4'h1;
							if (rx_bits_q == 4'h1) begin
								rx_state_q <= RX_IDLE;
								rx_done <= 1'b1;
								rx_data <= nine_en ? rx_shift_d[7:0] : rx_shift_d[8:1];
								rx_ninth <= nine_en ? rx_shift_d[8] : rx_shift_d[9];
							end
						end
					end
				end
				default: begin
					rx_state_q <= RX_IDLE;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// >>> verilog/dub_uart.v
`timescale 1ns/1ns
`default_nettype none
`include "dub_uart_defs.vh"

// ****************************************
// Dual serial port on the special function register bus
// ****************************************
module dub_uart (
	input wire clock,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_we,
	input wire sfr_re,
	output reg [7:0] sfr_rdata,
	input wire timer1_overflow,
	input wire ext_interrupt,
	input wire port0_rx,
	output wire port0_tx,
	input wire port1_rx,
	output wire port1_tx
);

	reg [7:0] power_control_q;
	reg [7:0] port0_control_q;
	reg [7:0] port1_control_q;
	reg [7:0] port0_rx_buffer_q;
	reg [7:0] port1_rx_buffer_q;
	reg baud_internal_q;
	reg [7:0] port0_reload_lo_q;
	reg [1:0] port0_reload_hi_q;
	reg [7:0] port1_reload_lo_q;
	reg [1:0] port1_reload_hi_q;
	reg [7:0] frame_options_q;
	reg [2:0] pin_s1_q;
	reg [2:0] pin_s2_q;
	reg [2:0] pin_s3_q;
	reg [2:0] pin_level_q;
	reg fixed_half_q;
	reg port0_half_q;
	reg port1_half_q;
	reg [7:0] rd_mux;

	wire rate_double;
	wire halted;
	wire [1:0] port0_mode;
	wire port0_nine;
	wire port1_nine;
	wire port0_multiproc_en;
	wire port1_multiproc_en;
	wire gen0_tick;
	wire gen1_tick;
	wire port0_src;
	wire port0_tick;
	wire port1_tick;
	wire wr_power;
	wire wr_port0_control;
	wire wr_port1_control;
	wire port0_tx_start;
	wire port1_tx_start;
	wire port0_tx_ninth;
	wire port1_tx_ninth;
	wire port0_tx_done;
	wire port1_tx_done;
	wire port0_rx_done;
	wire port1_rx_done;
	wire [7:0] port0_rx_data;
	wire [7:0] port1_rx_data;
	wire port0_rx_ninth;
	wire port1_rx_ninth;
	wire port0_accept;
	wire port1_accept;

	// ****************************************
	// Helper functions
	// ****************************************
	// A written one keeps the flag, a written zero clears it, a hardware set wins.
	function flag_next;
		input old;
		input write;
		input wbit;
		input set;
		begin
			flag_next = set | (old & ~(write & ~wbit));
		end
	endfunction

	// Multiprocessor mode drops frames whose ninth (or stop) bit is zero.
	function frame_accept;
		input done;
		input multiproc;
		input ninth;
		begin
			frame_accept = done & (~multiproc | ninth);
		end
	endfunction

	// Ninth bit is either software's bit or hardware parity when enabled.
	function ninth_bit;
		input [7:0] data;
		input soft_bit;
		input parity_en;
		input parity_odd;
		begin
			ninth_bit = parity_en ? (^data ^ parity_odd) : soft_bit;
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Bit 0 is the first port receive line, bit 1 the second, bit 2 the external interrupt.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 3'h3;
			pin_s2_q <= 3'h3;
			pin_s3_q <= 3'h3;
			pin_level_q <= 3'h3;
		end else begin
			pin_s1_q <= {ext_interrupt, port1_rx, port0_rx};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_level_q <= (pin_s2_q & pin_s3_q) | (pin_level_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	// ****************************************
	// Decoding
	// ****************************************
	assign rate_double = power_control_q[`DUB_PC_RATE_DOUBLE];
	assign halted = power_control_q[`DUB_PC_STOP];
	assign port0_mode = {port0_control_q[`DUB_CT_MODE_HI], port0_control_q[`DUB_CT_MODE_LO]};
	assign port0_nine = port0_mode[1];
	assign port1_nine = ~port1_control_q[`DUB_CT_MODE_HI];
	assign port0_multiproc_en = port0_control_q[`DUB_CT_MULTIPROC];
	assign port1_multiproc_en = port1_control_q[`DUB_CT_MULTIPROC];
	assign wr_power = sfr_we && (sfr_addr == `DUB_ADDR_POWER_CONTROL);
	assign wr_port0_control = sfr_we && (sfr_addr == `DUB_ADDR_PORT0_CONTROL);
	assign wr_port1_control = sfr_we && (sfr_addr == `DUB_ADDR_PORT1_CONTROL);
	// The unused first port mode neither sends nor receives.
	assign port0_tx_start = sfr_we && (sfr_addr == `DUB_ADDR_PORT0_BUFFER) && (port0_mode != 2'b00);
	assign port1_tx_start = sfr_we && (sfr_addr == `DUB_ADDR_PORT1_BUFFER);
	assign port0_tx_ninth = ninth_bit(sfr_wdata, port0_control_q[`DUB_CT_TX_NINTH],
		frame_options_q[`DUB_FO_PARITY_EN0], frame_options_q[`DUB_FO_PARITY_ODD0]);
	assign port1_tx_ninth = ninth_bit(sfr_wdata, port1_control_q[`DUB_CT_TX_NINTH],
		frame_options_q[`DUB_FO_PARITY_EN1], frame_options_q[`DUB_FO_PARITY_ODD1]);
	assign port0_accept = frame_accept(port0_rx_done, port0_multiproc_en, port0_rx_ninth);
	assign port1_accept = frame_accept(port1_rx_done, port1_multiproc_en, port1_rx_ninth);

	// ****************************************
	// Bit rate selection
	// ****************************************
	dub_baud #(
		.WIDTH(10)
	) u_gen0 (
		.clock(clock),
		.rst(rst),
		.reload({port0_reload_hi_q, port0_reload_lo_q}),
		.tick(gen0_tick)
	);

	dub_baud #(
		.WIDTH(10)
	) u_gen1 (
		.clock(clock),
		.rst(rst),
		.reload({port1_reload_hi_q, port1_reload_lo_q}),
		.tick(gen1_tick)
	);

	// Fixed mode runs on every second clock; timer 1 or generator otherwise.
	assign port0_src = (port0_mode == 2'b10) ? fixed_half_q :
		(baud_internal_q ? gen0_tick : timer1_overflow);
	// Without rate doubling only every second source pulse advances the port.
	assign port0_tick = port0_src & (rate_double | port0_half_q) & ~halted;
	assign port1_tick = gen1_tick & (rate_double | port1_half_q) & ~halted;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fixed_half_q <= 1'b0;
			port0_half_q <= 1'b0;
			port1_half_q <= 1'b0;
		end else begin
			fixed_half_q <= ~fixed_half_q;
			if (port0_src) begin
				port0_half_q <= ~port0_half_q;
			end
			if (gen1_tick) begin
				port1_half_q <= ~port1_half_q;
			end
		end
	end

	// ****************************************
	// Port engines
	// ****************************************
	dub_serial u_port0 (
		.clock(clock),
		.rst(rst),
		.tick(port0_tick),
		.nine_en(port0_nine),
		.two_stop(frame_options_q[`DUB_FO_TWO_STOP0]),
		.tx_start(port0_tx_start),
		.tx_data(sfr_wdata),
		.tx_ninth(port0_tx_ninth),
		.tx_pin(port0_tx),
		.tx_done(port0_tx_done),
		.rx_enable(port0_control_q[`DUB_CT_RX_ENABLE] && (port0_mode != 2'b00)),
		.rx_level(pin_level_q[0]),
		.rx_done(port0_rx_done),
		.rx_data(port0_rx_data),
		.rx_ninth(port0_rx_ninth)
	);

	dub_serial u_port1 (
		.clock(clock),
		.rst(rst),
		.tick(port1_tick),
		.nine_en(port1_nine),
		.two_stop(frame_options_q[`DUB_FO_TWO_STOP1]),
		.tx_start(port1_tx_start),
		.tx_data(sfr_wdata),
		.tx_ninth(port1_tx_ninth),
		.tx_pin(port1_tx),
		.tx_done(port1_tx_done),
		.rx_enable(port1_control_q[`DUB_CT_RX_ENABLE]),
		.rx_level(pin_level_q[1]),
		.rx_done(port1_rx_done),
		.rx_data(port1_rx_data),
		.rx_ninth(port1_rx_ninth)
	);

	// ****************************************
	// Register writes and hardware updates
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			power_control_q <= `DUB_RST_BYTE;
			port0_control_q <= `DUB_RST_BYTE;
			port1_control_q <= `DUB_RST_BYTE;
			port0_rx_buffer_q <= `DUB_RST_BYTE;
			port1_rx_buffer_q <= `DUB_RST_BYTE;
			baud_internal_q <= 1'b0;
			port0_reload_lo_q <= `DUB_RST_RELOAD_LO;
			port0_reload_hi_q <= `DUB_RST_RELOAD_HI;
			port1_reload_lo_q <= `DUB_RST_RELOAD_LO;
			port1_reload_hi_q <= `DUB_RST_RELOAD_HI;
			frame_options_q <= `DUB_RST_BYTE;
		end else begin
			if (wr_power) begin
				power_control_q <= {sfr_wdata[7], 5'b00000, sfr_wdata[1:0]};
			end
			// An external interrupt ends the halt and wins over a write.
			if (pin_level_q[2]) begin
				power_control_q[`DUB_PC_STOP] <= 1'b0;
			end
			if (wr_port0_control) begin
				port0_control_q[7:3] <= sfr_wdata[7:3];
			end
			if (wr_port1_control) begin
				port1_control_q[7] <= sfr_wdata[7];
				port1_control_q[5:3] <= sfr_wdata[5:3];
			end
			port0_control_q[`DUB_CT_RX_NINTH] <= port0_accept ? port0_rx_ninth :
				(wr_port0_control ? sfr_wdata[`DUB_CT_RX_NINTH] : port0_control_q[`DUB_CT_RX_NINTH]);
			port1_control_q[`DUB_CT_RX_NINTH] <= port1_accept ? port1_rx_ninth :
				(wr_port1_control ? sfr_wdata[`DUB_CT_RX_NINTH] : port1_control_q[`DUB_CT_RX_NINTH]);
			port0_control_q[`DUB_CT_TX_DONE] <= flag_next(port0_control_q[`DUB_CT_TX_DONE],
				wr_port0_control, sfr_wdata[`DUB_CT_TX_DONE], port0_tx_done);
			port0_control_q[`DUB_CT_RX_DONE] <= flag_next(port0_control_q[`DUB_CT_RX_DONE],
				wr_port0_control, sfr_wdata[`DUB_CT_RX_DONE], port0_accept);
			port1_control_q[`DUB_CT_TX_DONE] <= flag_next(port1_control_q[`DUB_CT_TX_DONE],
				wr_port1_control, sfr_wdata[`DUB_CT_TX_DONE], port1_tx_done);
			port1_control_q[`DUB_CT_RX_DONE] <= flag_next(port1_control_q[`DUB_CT_RX_DONE],
				wr_port1_control, sfr_wdata[`DUB_CT_RX_DONE], port1_accept);
			if (port0_accept) begin
				port0_rx_buffer_q <= port0_rx_data;
			end
			if (port1_accept) begin
				port1_rx_buffer_q <= port1_rx_data;
			end
			if (sfr_we) begin
				case (sfr_addr)
				`DUB_ADDR_BAUD_SOURCE: baud_internal_q <= sfr_wdata[`DUB_BS_INTERNAL];
				`DUB_ADDR_PORT0_RELOAD_LO: port0_reload_lo_q <= sfr_wdata;
				`DUB_ADDR_PORT0_RELOAD_HI: port0_reload_hi_q <= sfr_wdata[1:0];
				`DUB_ADDR_PORT1_RELOAD_LO: port1_reload_lo_q <= sfr_wdata;
				`DUB_ADDR_PORT1_RELOAD_HI: port1_reload_hi_q <= sfr_wdata[1:0];
				`DUB_ADDR_FRAME_OPTIONS: frame_options_q <= {1'b0, sfr_wdata[6:4], 1'b0, sfr_wdata[2:0]};
				default: begin
				end
				endcase
			end
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	always @* begin
		case (sfr_addr)
		`DUB_ADDR_POWER_CONTROL: rd_mux = power_control_q;
		`DUB_ADDR_PORT0_CONTROL: rd_mux = port0_control_q;
		`DUB_ADDR_PORT0_BUFFER: rd_mux = port0_rx_buffer_q;
		`DUB_ADDR_PORT1_CONTROL: rd_mux = port1_control_q;
		`DUB_ADDR_PORT1_BUFFER: rd_mux = port1_rx_buffer_q;
		`DUB_ADDR_BAUD_SOURCE: rd_mux = {baud_internal_q, 7'h00};
		`DUB_ADDR_PORT0_RELOAD_LO: rd_mux = port0_reload_lo_q;
		`DUB_ADDR_PORT0_RELOAD_HI: rd_mux = {6'h00, port0_reload_hi_q};
		`DUB_ADDR_PORT1_RELOAD_LO: rd_mux = port1_reload_lo_q;
		`DUB_ADDR_PORT1_RELOAD_HI: rd_mux = {6'h00, port1_reload_hi_q};
		`DUB_ADDR_FRAME_OPTIONS: rd_mux = frame_options_q;
		default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_re) begin
			sfr_rdata <= rd_mux;
		end
	end

endmodule
`default_nettype wire

// >>> dv/dub_uart_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port level checks of the dual serial port
// ****************************************
module dub_uart_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_we,
	input wire logic sfr_re,
	input wire logic [7:0] sfr_rdata,
	input wire logic timer1_overflow,
	input wire logic ext_interrupt,
	input wire logic port0_rx,
	input wire logic port0_tx,
	input wire logic port1_rx,
	input wire logic port1_tx
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_TX_IDLE_AFTER_RESET: assert property ($fell(rst) |-> port0_tx && port1_tx)
		else $error("serial output not idle after reset");
	AST_RDATA_HOLDS: assert property (!sfr_re |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	AST_UNMAPPED_READS_ZERO: assert property (sfr_re && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
		else $error("unmapped address read not zero");
	AST_PORT0_LOW_LENGTH: assert property ($fell(port0_tx) |-> !port0_tx [*8])
		else $error("first port low bit too short");
	AST_PORT1_LOW_LENGTH: assert property ($fell(port1_tx) |-> !port1_tx [*8])
		else $error("second port low bit too short");
	AST_PORT0_HIGH_LENGTH: assert property ($rose(port0_tx) |-> port0_tx [*8])
		else $error("first port high bit too short");
	AST_PORT1_MODE_BIT6_ZERO: assert property (sfr_re && sfr_addr == 8'h9B |=> sfr_rdata[6] == 1'b0)
		else $error("second port control bit 6 not zero");
	AST_POWER_UNUSED_ZERO: assert property (sfr_re && sfr_addr == 8'h87 |=> sfr_rdata[6:2] == 5'h00)
		else $error("power control unused bits not zero");
	AST_RATE_DOUBLE_READBACK: assert property (sfr_we && sfr_addr == 8'h87 ##2 sfr_re && sfr_addr == 8'h87
		|=> sfr_rdata[7] == $past(sfr_wdata[7], 3))
		else $error("rate doubling bit not stored");
	AST_BAUD_SOURCE_READBACK: assert property (sfr_we && sfr_addr == 8'hD8 ##2 sfr_re && sfr_addr == 8'hD8
		|=> sfr_rdata[7] == $past(sfr_wdata[7], 3))
		else $error("baud source bit not stored");
endmodule
bind dub_uart dub_uart_checker checker_u (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .timer1_overflow(timer1_overflow),
	.ext_interrupt(ext_interrupt), .port0_rx(port0_rx), .port0_tx(port0_tx), .port1_rx(port1_rx),
	.port1_tx(port1_tx));
`default_nettype wire

// >>> dv/dub_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Serial host on the far side of one port
// ****************************************
module dub_host_model (
	input wire logic clock,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	task automatic send(input logic [8:0] data, input int nbits, input int bit_clks);
		for (int i = -1; i <= nbits; i++) begin
			line_out = (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : data[i];
			repeat (bit_clks) @(negedge clock);
		end
	endtask
	// Returns data bits then the stop bit, each sampled mid bit.
	task automatic capture(input int nbits, input int bit_clks, output logic [9:0] data, output logic lost);
		int n;
		n = 0;
		data = 10'h000;
		while (line_in === 1'b1 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		lost = (n >= 20000);
		repeat (bit_clks / 2) @(negedge clock);
		for (int i = 0; i <= nbits; i++) begin
			repeat (bit_clks) @(negedge clock);
			data[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// >>> dv/dub_testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin bad_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, act, exp); end end
module testbench;
	logic clock, rst, sfr_we, sfr_re, timer1_overflow, ext_interrupt, t1_run, lost0, lost1;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [9:0] got0, got1;
	wire logic port0_rx, port0_tx, port1_rx, port1_tx;
	int bad_count, checks_done;
	logic [7:0] regs [7] = '{8'h87, 8'h98, 8'h99, 8'h9B, 8'h9C, 8'hD8, 8'h00};
	dub_uart dut_u (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
		.sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .timer1_overflow(timer1_overflow),
		.ext_interrupt(ext_interrupt), .port0_rx(port0_rx), .port0_tx(port0_tx), .port1_rx(port1_rx),
		.port1_tx(port1_tx));
	dub_host_model host0_u (.clock(clock), .line_in(port0_tx), .line_out(port0_rx));
	dub_host_model host1_u (.clock(clock), .line_in(port1_tx), .line_out(port1_rx));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(negedge clock) timer1_overflow <= t1_run & ~timer1_overflow;
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_we = 1'b1;
		@(negedge clock);
		sfr_we = 1'b0;
		@(negedge clock);
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		sfr_re = 1'b1;
		@(negedge clock);
		sfr_re = 1'b0;
		`CHK(sfr_rdata, e)
		@(negedge clock);
	endtask
	function automatic logic [9:0] framed(input logic [8:0] v, input int nbits);
		return (nbits == 9) ? {1'b1, v} : {2'b01, v[7:0]};
	endfunction
	task automatic lost_check;
		if (lost0 | lost1) begin
			bad_count++;
			complete_run();
		end
	endtask
	// Both ports send and receive at once; tx values carry the expected ninth bit.
	task automatic frame_pair(input logic [8:0] tx0, tx1, rx0, rx1, input int nbits, input int bclk);
		fork
			begin
				wr(8'h99, tx0[7:0]);
				wr(8'h9C, tx1[7:0]);
			end
			host0_u.capture(nbits, bclk, got0, lost0);
			host1_u.capture(nbits, bclk, got1, lost1);
			host0_u.send(rx0, nbits, bclk);
			host1_u.send(rx1, nbits, bclk);
		join
		repeat (8) @(negedge clock);
		lost_check();
		`CHK(got0, framed(tx0, nbits))
		`CHK(got1, framed(tx1, nbits))
	endtask
	task automatic tx0(input logic [8:0] v, input int nbits, input int bclk);
		lost1 = 1'b0;
		fork
			wr(8'h99, v[7:0]);
			host0_u.capture(nbits, bclk, got0, lost0);
		join
		repeat (bclk) @(negedge clock);
		lost_check();
		`CHK(got0, framed(v, nbits))
	endtask
	initial begin
		{rst, sfr_we, sfr_re, ext_interrupt, t1_run} = 5'b10000;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		bad_count = 0;
		checks_done = 0;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		for (int i = 0; i < 7; i++) chk(regs[i], 8'h00);
		wr(8'h87, 8'h80);
		chk(8'h87, 8'h80);
		wr(8'hD8, 8'h80);
		chk(8'hD8, 8'h80);
		wr(8'hA1, 8'hFF);
		wr(8'hA2, 8'h03);
		wr(8'hA3, 8'hFF);
		wr(8'hA4, 8'h03);
		wr(8'h98, 8'h50);
		wr(8'h9B, 8'h90);
		frame_pair(9'h0A5, 9'h05A, 9'h03C, 9'h0C3, 8, 16);
		chk(8'h98, 8'h57);
		chk(8'h9B, 8'h97);
		chk(8'h99, 8'h3C);
		chk(8'h9C, 8'hC3);
		wr(8'h98, 8'h57);
		chk(8'h98, 8'h57);
		wr(8'h98, 8'h55);
		chk(8'h98, 8'h55);
		wr(8'h98, 8'h54);
		chk(8'h98, 8'h54);
		wr(8'h98, 8'hD8);
		wr(8'h9B, 8'h18);
		frame_pair(9'h196, 9'h169, 9'h011, 9'h1EE, 9, 16);
		chk(8'h98, 8'hDB);
		chk(8'h9B, 8'h1F);
		chk(8'h99, 8'h11);
		chk(8'h9C, 8'hEE);
		wr(8'h98, 8'hF0);
		host0_u.send(9'h044, 9, 16);
		chk(8'h98, 8'hF0);
		chk(8'h99, 8'h11);
		host0_u.send(9'h1A2, 9, 16);
		chk(8'h98, 8'hF5);
		chk(8'h99, 8'hA2);
		wr(8'h9B, 8'h80);
		host1_u.send(9'h077, 8, 16);
		chk(8'h9B, 8'h80);
		chk(8'h9C, 8'hEE);
		// Odd parity of the data gives a ninth bit of one while the software bit is zero.
		wr(8'hA5, 8'h03);
		wr(8'h98, 8'h80);
		for (int d = 1; d >= 0; d--) begin
			wr(8'h87, d ? 8'h80 : 8'h00);
			tx0(9'h13C, 9, d ? 32 : 64);
		end
		t1_run = 1'b1;
		wr(8'h87, 8'h80);
		wr(8'hD8, 8'h00);
		wr(8'h98, 8'h40);
		tx0(9'h0C5, 8, 32);
		wr(8'h87, 8'h82);
		wr(8'h9C, 8'h5A);
		lost0 = 1'b0;
		fork
			host1_u.capture(8, 16, got1, lost1);
			begin
				repeat (100) @(negedge clock);
				`CHK(port1_tx, 1'b1)
				ext_interrupt = 1'b1;
				repeat (5) @(negedge clock);
				ext_interrupt = 1'b0;
			end
		join
		lost_check();
		`CHK(got1, 10'h15A)
		chk(8'h87, 8'h80);
		complete_run();
	end
endmodule
`default_nettype wire
